//--- logic/pfcsq_top.sv
// standby detection, fault timer, burst and latch-off sequencing
// assumes rst_n follows the supply turn-on comparator, supply_por_n follows
// the deep power-down level; comparator inputs are asynchronous
`timescale 1ns/100ps
module pfcsq_top #(
  parameter int SS_CYC = pfcsq_pkg::SS_CYCLES,
  parameter int DITHER_CYC = pfcsq_pkg::DITHER_CYCLES,
  parameter int DELAY_CYC = pfcsq_pkg::DELAY_CYCLES
) (
  // clock and reset (reset = supply above turn-on level)
  input wire logic clk,
  input wire logic rst_n,
  // supply cycled fully down, clears the major-fault latch
  input wire logic supply_por_n,
  // analog comparator inputs
  input wire logic setpoint_at_clamp,
  input wire logic skip_active,
  input wire logic fault_detect,
  input wire logic supply_undervoltage,
  // outputs
  output logic pfc_enable_request,
  output logic pfc_sink_enable,
  output logic drive_enable,
  output logic soft_start_done,
  output logic [pfcsq_pkg::LIMIT_W-1:0] current_limit,
  output logic error_flag,
  output logic fault_active,
  output logic standby_active,
  output logic major_fault,
  output logic [pfcsq_pkg::CNT_W-1:0] dither_ramp
);
  localparam logic [pfcsq_pkg::CNT_W-1:0] SS_N = SS_CYC[pfcsq_pkg::CNT_W-1:0];
  localparam logic [pfcsq_pkg::CNT_W-1:0] DIT_N =
    DITHER_CYC[pfcsq_pkg::CNT_W-1:0];
  localparam logic [pfcsq_pkg::CNT_W-1:0] DLY_N =
    DELAY_CYC[pfcsq_pkg::CNT_W-1:0];

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic clamp_s;
  logic skip_s;
  logic fdet_s;
  logic uv_s;

  pfcsq_sync u_sync_clamp (.clk(clk), .rst_n(rst_n),
    .din(setpoint_at_clamp), .dout(clamp_s));
  pfcsq_sync u_sync_skip (.clk(clk), .rst_n(rst_n),
    .din(skip_active), .dout(skip_s));
  pfcsq_sync u_sync_fdet (.clk(clk), .rst_n(rst_n),
    .din(fault_detect), .dout(fdet_s));
  pfcsq_sync u_sync_uv (.clk(clk), .rst_n(rst_n),
    .din(supply_undervoltage), .dout(uv_s));

  // --------------------------------------------------------------------
  // state and counters
  // --------------------------------------------------------------------
  pfcsq_pkg::pfcsq_state_t state_reg;
  logic [pfcsq_pkg::CNT_W-1:0] ss_cnt_reg;
  logic [pfcsq_pkg::CNT_W-1:0] flt_cnt_reg;
  logic [pfcsq_pkg::CNT_W-1:0] sb_cnt_reg;
  logic [pfcsq_pkg::CNT_W-1:0] burst_cnt_reg;
  logic latch_reg;
  logic err_seen_reg;
  logic fault_confirm;

  assign error_flag = clamp_s;
  // confirm one cycle early so BURST follows DELAY_CYC error cycles
  assign fault_confirm = clamp_s && (flt_cnt_reg >= DLY_N - 1'b1);

  // major-fault latch survives rst_n, cleared only by deep power-down
  always_ff @(posedge clk) begin
    if (!supply_por_n) begin
      latch_reg <= 1'b0;
    end else if (fdet_s) begin
      latch_reg <= 1'b1;
    end
  end

  // soft-start counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_cnt_reg <= '0;
    end else if (state_reg == pfcsq_pkg::PFCSQ_START &&
        ss_cnt_reg < SS_N) begin
      ss_cnt_reg <= ss_cnt_reg + 1'b1;
    end
  end

  // fault-confirmation timer, restarts on each error assertion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flt_cnt_reg <= '0;
    end else if (!clamp_s) begin
      flt_cnt_reg <= '0;
    end else if (flt_cnt_reg < DLY_N) begin
      flt_cnt_reg <= flt_cnt_reg + 1'b1;
    end
  end

  // free dither ramp while no error timing is in progress
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dither_ramp <= '0;
    end else if (clamp_s) begin
      dither_ramp <= '0;
    end else if (dither_ramp >= DIT_N - 1'b1) begin
      dither_ramp <= '0;
    end else begin
      dither_ramp <= dither_ramp + 1'b1;
    end
  end

  // standby confirmation countdown
  always_ff @(posedge clk) begin
    if (!rst_n || !skip_s) begin
      sb_cnt_reg <= '0;
    end else if (sb_cnt_reg < DLY_N) begin
      sb_cnt_reg <= sb_cnt_reg + 1'b1;
    end
  end
  assign standby_active = skip_s && (sb_cnt_reg == DLY_N);

  // burst attempt length
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != pfcsq_pkg::PFCSQ_BURST) begin
      burst_cnt_reg <= '0;
    end else if (burst_cnt_reg < DLY_N) begin
      burst_cnt_reg <= burst_cnt_reg + 1'b1;
    end
  end

  // error seen cleared after power-on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_seen_reg <= 1'b0;
    end else if (state_reg == pfcsq_pkg::PFCSQ_RUN && !clamp_s) begin
      err_seen_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= pfcsq_pkg::PFCSQ_START;
    end else if (latch_reg || fdet_s) begin
      state_reg <= pfcsq_pkg::PFCSQ_LATCHED;
    end else begin
      case (state_reg)
        pfcsq_pkg::PFCSQ_START: begin
          if (fault_confirm) begin
            state_reg <= pfcsq_pkg::PFCSQ_BURST;
          end else if (ss_cnt_reg >= SS_N) begin
            state_reg <= pfcsq_pkg::PFCSQ_RUN;
          end
        end
        pfcsq_pkg::PFCSQ_RUN: begin
          if (fault_confirm) begin
            state_reg <= pfcsq_pkg::PFCSQ_BURST;
          end
        end
        pfcsq_pkg::PFCSQ_BURST: begin
          // switching stopped; go to OFF after DELAY_CYC burst cycles or on supply undervoltage
          if (burst_cnt_reg >= DLY_N || uv_s) begin
            state_reg <= pfcsq_pkg::PFCSQ_OFF;
          end
        end
        pfcsq_pkg::PFCSQ_OFF: state_reg <= pfcsq_pkg::PFCSQ_OFF;
        pfcsq_pkg::PFCSQ_LATCHED: state_reg <= pfcsq_pkg::PFCSQ_LATCHED;
        default: state_reg <= pfcsq_pkg::PFCSQ_OFF;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // pfc request qualifiers
  // --------------------------------------------------------------------
  // the pfc may only follow a running pwm section that has left its
  // power-on error phase; a detect blocks it in the same cycle as the latch
  logic pwm_running;
  logic pfc_blocked;
  assign pwm_running = (state_reg == pfcsq_pkg::PFCSQ_RUN) &&
    (err_seen_reg || !clamp_s);
  assign pfc_blocked = latch_reg || fdet_s || fault_confirm ||
    standby_active;

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pfc_enable_request <= 1'b0;
    end else begin
      pfc_enable_request <= pwm_running && !pfc_blocked;
    end
  end
  assign pfc_sink_enable = pfc_enable_request;

  // a set latch blocks pulses even while reset parks the state at START
  assign drive_enable = !latch_reg &&
    ((state_reg == pfcsq_pkg::PFCSQ_START) ||
    (state_reg == pfcsq_pkg::PFCSQ_RUN));
  assign fault_active = (state_reg == pfcsq_pkg::PFCSQ_BURST) ||
    (state_reg == pfcsq_pkg::PFCSQ_OFF);
  assign major_fault = latch_reg;
  assign soft_start_done = (ss_cnt_reg >= SS_N);

  // linear limit ramp, then held at the clamp
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      current_limit <= '0;
    end else if (ss_cnt_reg >= SS_N) begin
      current_limit <= pfcsq_pkg::LIMIT_MAX;
    end else begin
      current_limit <= 8'((32'(ss_cnt_reg) * 255) / SS_CYC);
    end
  end
endmodule

//--- logic/pfcsq_pkg.sv
// timing constants and state encoding for the standby/fault sequencer
// assumes a 10 MHz logic clock; durations fixed at the reference timing capacitor
//
// Summary of operation
// - pfc_enable_request high enables the 1 mA sink on the PFC output.
// - pfc_enable_request low switches the sink off; output pulled up.
// - above turn-on level the device starts delivering drive pulses.
// - soft-start ramps the current limit linearly, then holds the clamp.
// - error flag asserted while setpoint sits at the maximum clamp.
// - each error flag assertion starts the fault-confirmation countdown.
// - error held for full delay: fault, stop switching, enter burst mode.
// - error released early: transient, keep switching, no fault.
// - at power-on keep pfc request low until the error flag deasserts.
// - skip activity for 100 ms confirms standby, pfc request low.
// - skip activity gone: pfc request high at once, no timer.
// - confirmed overload keeps pfc request low through all bursts.
// - PFC enabled only after the PWM section is running.
// - soft-start, dither and fault delays scale with the capacitor; here fixed cycle counts set at the 390 nF reference.
// - error cleared early resets the timer for reuse as dither ramp.
// - burst attempt lasts at most 100 ms, ends early on undervoltage.
// - fault-detect above threshold latches switching off until power-down.
package pfcsq_pkg;
  localparam int CLK_HZ = 10000000;
  // reference capacitance and times at that capacitance
  localparam int CAP_REF_NF = 390;
  localparam int SS_TIME_US = 7500;
  localparam int DITHER_TIME_US = 10000;
  localparam int DELAY_TIME_US = 100000;
  localparam int SS_CYCLES = SS_TIME_US * (CLK_HZ / 1000000);
  localparam int DITHER_CYCLES = DITHER_TIME_US * (CLK_HZ / 1000000);
  localparam int DELAY_CYCLES = DELAY_TIME_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 24;
  localparam int LIMIT_W = 8;
  localparam logic [7:0] LIMIT_MAX = 8'hff;

  typedef enum logic [2:0] {
    PFCSQ_OFF     = 3'h0,
    PFCSQ_START   = 3'h1,
    PFCSQ_RUN     = 3'h2,
    PFCSQ_BURST   = 3'h3,
    PFCSQ_LATCHED = 3'h4
  } pfcsq_state_t;
endpackage

//--- logic/pfcsq_sync.sv
// three-stage synchroniser with agreement filter for a comparator output
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
module pfcsq_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // async in, clean out
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      dout <= s3_reg;
    end
  end
endmodule

//--- test/pfcsq_pnp_model.sv
// model of the pnp switch that feeds the pfc controller supply
// assumes the base is pulled to the supply unless the 1 mA sink is on
`timescale 1ns/100ps
module pfcsq_pnp_model (
  // sink control from the sequencer
  input wire logic pfc_sink_enable,
  // pfc controller supply present
  output logic pfc_supply_on
);
  // sink on pulls the base low and turns the switch on
  assign pfc_supply_on = (pfc_sink_enable === 1'b1);
endmodule

//--- test/pfcsq_top_properties.sv
// concurrent checks on the sequencer outputs
// assumes binding into pfcsq_top, one clock domain
`timescale 1ns/100ps
module pfcsq_top_properties #(
  parameter int DELAY_CYC = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic skip_active,
  input wire logic pfc_enable_request,
  input wire logic pfc_sink_enable,
  input wire logic drive_enable,
  input wire logic soft_start_done,
  input wire logic [pfcsq_pkg::LIMIT_W-1:0] current_limit,
  input wire logic error_flag,
  input wire logic fault_active,
  input wire logic standby_active,
  input wire logic major_fault
);
  // ----------------
  // run counters
  // ----------------
  logic [7:0] err_cnt;
  logic [7:0] skip_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || !error_flag) begin
      err_cnt <= 8'h00;
    end else if (err_cnt != 8'hff) begin
      err_cnt <= err_cnt + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !skip_active) begin
      skip_cnt <= 8'h00;
    end else if (skip_cnt != 8'hff) begin
      skip_cnt <= skip_cnt + 8'h01;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_err_long;
    err_cnt == DELAY_CYC + 3;
  endsequence
  sequence s_woken;
    $fell(standby_active) && !fault_active && !major_fault && !error_flag;
  endsequence
  chk_sink_req: assert property (
    pfc_sink_enable == pfc_enable_request) else $error("sink mismatch");
  chk_clamp_held: assert property (
    soft_start_done |=> current_limit == pfcsq_pkg::LIMIT_MAX)
    else $error("limit not at clamp");
  chk_pfc_after_pwm: assert property (
    !soft_start_done |-> !pfc_enable_request) else $error("pfc too early");
  chk_fault_delay: assert property (
    $rose(fault_active) |-> err_cnt >= DELAY_CYC - 2
    && err_cnt <= DELAY_CYC + 2) else $error("fault at wrong time");
  chk_fault_stops: assert property (
    s_err_long |-> !drive_enable) else $error("drive after fault");
  chk_burst_pfc_off: assert property (
    fault_active |-> !pfc_enable_request) else $error("pfc on in fault");
  chk_latch_off: assert property (
    major_fault |-> !pfc_enable_request && !drive_enable)
    else $error("active while latched");
  chk_standby_time: assert property (
    $rose(standby_active) |-> skip_cnt >= DELAY_CYC)
    else $error("standby too early");
  chk_wake_fast: assert property (
    s_woken |-> ##[0:1] pfc_enable_request) else $error("slow wake");
  chk_sink_standby: assert property (
    standby_active |=> !pfc_sink_enable) else $error("sink on in standby");
  chk_start_drives: assert property (
    $rose(rst_n) |-> drive_enable == !major_fault)
    else $error("wrong drive at turn-on");
endmodule
bind pfcsq_top pfcsq_top_properties #(.DELAY_CYC(DELAY_CYC))
  i_pfcsq_top_properties (.*);

//--- test/pfcsq_top_tb.sv
// self-checking bench for the standby and fault sequencer
// assumes short counts: soft-start 20, dither 30, delay 50 cycles
`timescale 1ns/100ps
module pfcsq_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_por_n = 1'b0;
  logic clamp = 1'b0;
  logic skip = 1'b0;
  logic detect = 1'b0;
  logic uv = 1'b0;
  logic req, sink, drive, ss_done, err, fault, stby, major, supply_on;
  logic [pfcsq_pkg::LIMIT_W-1:0] limit;
  logic [pfcsq_pkg::CNT_W-1:0] ramp, ramp_seen;
  int errors = 0;
  int checked = 0;
  always #50 clk = ~clk;
  pfcsq_top #(.SS_CYC(20), .DITHER_CYC(30), .DELAY_CYC(50)) i_pfcsq_top (
    .clk(clk), .rst_n(rst_n), .supply_por_n(supply_por_n),
    .setpoint_at_clamp(clamp), .skip_active(skip), .fault_detect(detect),
    .supply_undervoltage(uv), .pfc_enable_request(req),
    .pfc_sink_enable(sink), .drive_enable(drive),
    .soft_start_done(ss_done), .current_limit(limit), .error_flag(err),
    .fault_active(fault), .standby_active(stby), .major_fault(major),
    .dither_ramp(ramp));
  pfcsq_pnp_model i_pfcsq_pnp_model (.pfc_sink_enable(sink),
    .pfc_supply_on(supply_on));
  task automatic end_sim();
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic c, input logic s, input logic d,
    input logic u);
    @(posedge clk);
    clamp <= c;
    skip <= s;
    detect <= d;
    uv <= u;
  endtask
  task automatic rst(input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    supply_por_n <= p;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    supply_por_n <= 1'b1;
  endtask
  initial begin
    rst(1'b0);
    put(1'b1, 1'b0, 1'b0, 1'b0);
    wt(9);
    chk(limit, 8'h66);
    chk(ss_done, 1'h0);
    wt(21);
    chk(drive, 1'b1);
    chk(limit, 8'hff);
    chk(err, 1'b1);
    chk(req, 1'b0);
    chk(ramp, 24'h0);
    put(1'b0, 1'b0, 1'b0, 1'b0);
    wt(8);
    chk(req, 1'b1);
    chk(supply_on, 1'b1);
    ramp_seen = ramp;
    wt(3);
    chk(ramp != ramp_seen, 1'b1);
    // two short errors must not add up to a fault
    repeat (2) begin
      put(1'b1, 1'b0, 1'b0, 1'b0);
      wt(40);
      put(1'b0, 1'b0, 1'b0, 1'b0);
      wt(8);
      chk(fault, 1'b0);
      chk(req, 1'b1);
    end
    put(1'b0, 1'b1, 1'b0, 1'b0);
    wt(30);
    chk(req, 1'b1);
    wt(30);
    chk(stby, 1'b1);
    chk(supply_on, 1'b0);
    put(1'b0, 1'b0, 1'b0, 1'b0);
    wt(7);
    chk(req, 1'b1);
    put(1'b1, 1'b0, 1'b0, 1'b0);
    wt(62);
    chk(drive, 1'b0);
    chk(req, 1'b0);
    put(1'b0, 1'b0, 1'b0, 1'b1);
    wt(10);
    chk(fault, 1'b1);
    rst(1'b1);
    wt(30);
    chk(req, 1'b1);
    put(1'b0, 1'b0, 1'b1, 1'b0);
    wt(8);
    chk(drive, 1'b0);
    chk(major, 1'b1);
    chk(req, 1'b0);
    put(1'b0, 1'b0, 1'b0, 1'b0);
    rst(1'b1);
    wt(30);
    chk(major, 1'b1);
    chk(drive, 1'b0);
    chk(req, 1'b0);
    rst(1'b0);
    wt(30);
    chk(req, 1'b1);
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
